// [hdl/tws_pkg.sv]
// Package with register map, field layout and timing constants of the slave
package tws_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL0 = 8'h00;
    localparam logic [7:0] OFF_CTRL1 = 8'h04;
    localparam logic [7:0] OFF_ADDR = 8'h08;
    localparam logic [7:0] OFF_DATA = 8'h0C;
    localparam logic [7:0] OFF_TOC = 8'h10;
    // First control register fields
    localparam int CTRL0_MODE_LSB = 0;
    localparam int CTRL0_EN_BIT = 3;
    localparam logic [2:0] MODE_TWO_WIRE = 3'b110;
    localparam logic [7:0] CTRL0_RESET = 8'h00;
    // Second control register fields
    localparam int CTRL1_MATCH_BIT = 6;
    localparam int CTRL1_BUSY_BIT = 5;
    localparam int CTRL1_TXSEL_BIT = 4;
    localparam int CTRL1_TXACK_BIT = 3;
    localparam int CTRL1_SRW_BIT = 2;
    localparam int CTRL1_RXACK_BIT = 0;
    localparam logic RXACK_RESET = 1'b1;
    // Own address and data reset values
    localparam logic [6:0] ADDR_RESET = 7'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // Time-out control register fields
    localparam int TOC_EN_BIT = 7;
    localparam int TOC_FLAG_BIT = 6;
    localparam logic [7:0] TOC_RESET = 8'h00;
    // Sub-clock prescale and byte length
    localparam int TO_PRESCALE = 32;
    localparam logic [4:0] TO_PRESCALE_LAST = 5'(TO_PRESCALE - 1);
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // Bus-side serial states
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_HOLD, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK
    } tws_state_e;

    // Sampled bus lines
    typedef struct packed {
        logic scl;
        logic sda;
    } tws_pins_in_s;

    // Open-drain pin drive, enables low while pulling the line low
    typedef struct packed {
        logic sclOut;
        logic sclOeN;
        logic sdaOut;
        logic sdaOeN;
    } tws_pins_out_s;
endpackage

// [hdl/tws_slave.sv]
// Two-wire bus slave with lock-up time-out and APB register access
// Function
// - Slave active only with mode 110 and enable
// - SDA fall with SCL high sets busy
// - Shift seven address bits, match sets flag, interrupt
// - Eighth bit stored as master read flag
// - Acknowledge matched address low on ninth clock
// - Interrupt from match, byte done, time-out
// - Stretch clock until data written or read
// - Transmit select chooses send or receive
// - Data bytes eight bits, MSB first
// - Receiver acknowledges ninth clock with ack level
// - No master acknowledge: release, await stop
// - Shared data register holds received/transmit bytes
// - Time-out starts on match, cleared by SCL fall
// - Stop condition halts the time-out counter
// - Period is (select plus one) times 32 sub-clocks
// - Time-out stops counter, clears enable, sets flag
// - Time-out resets slave and second control register
// - Software may clear the time-out flag
// - Received ack flag zero when master acknowledged
//
// Added by the designer: the APB slave port and the register offsets.
module tws_slave
    import tws_pkg::*;
(
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sub-clock strobe, one cycle per sub-clock period
    input wire logic subClkTick,
    // Two-wire bus pins
    input wire tws_pins_in_s pinsIn,
    output tws_pins_out_s pinsOut,
    // Module interrupt pulse
    output logic irqPulse
);
    // Software-visible registers
    logic [7:0] ctrl0Q;
    logic [6:0] ownAddrQ;
    logic [7:0] dataQ;
    logic [7:0] tocQ;
    // Second control register flags
    logic matchQ, busyQ, txSelQ, txAckQ, srwQ, rxAckQ;
    // Serial engine state
    tws_state_e stateQ;
    logic [7:0] shiftQ;
    logic [3:0] bitCntQ;
    logic sclPrevQ, sdaPrevQ;
    logic sclOeNQ, sdaOeNQ;
    // Time-out counters
    logic toRunQ;
    logic [4:0] preCntQ;
    logic [5:0] perCntQ;
    // Interrupt and APB answer
    logic irqQ;
    logic [31:0] prdataQ;
    logic preadyQ, pslverrQ;

    // APB decode
    wire logic apbAccess = psel & penable;
    wire logic apbDone = apbAccess & preadyQ;
    wire logic selCtrl0 = paddr == OFF_CTRL0;
    wire logic selCtrl1 = paddr == OFF_CTRL1;
    wire logic selAddr = paddr == OFF_ADDR;
    wire logic selData = paddr == OFF_DATA;
    wire logic selToc = paddr == OFF_TOC;
    wire logic mapped = selCtrl0 | selCtrl1 | selAddr | selData | selToc;
    wire logic wrDone = apbDone & pwrite & mapped;
    wire logic wrCtrl0 = wrDone & selCtrl0;
    wire logic wrCtrl1 = wrDone & selCtrl1;
    wire logic wrAddr = wrDone & selAddr;
    wire logic wrData = wrDone & selData;
    wire logic wrToc = wrDone & selToc;
    wire logic rdData = apbDone & ~pwrite & selData;

    // Read data selection
    wire logic [7:0] ctrl1Rd = {1'b0, matchQ, busyQ, txSelQ, txAckQ, srwQ, 1'b0, rxAckQ};
    wire logic [7:0] rdByte = selCtrl0 ? ctrl0Q :
                              selCtrl1 ? ctrl1Rd :
                              selAddr ? {1'b0, ownAddrQ} :
                              selData ? dataQ :
                              selToc ? tocQ : 8'h00;

    wire logic active = ctrl0Q[CTRL0_EN_BIT] & (ctrl0Q[CTRL0_MODE_LSB +: 3] == MODE_TWO_WIRE);

    // Bus condition detection
    wire logic sclRise = pinsIn.scl & ~sclPrevQ;
    wire logic sclFall = ~pinsIn.scl & sclPrevQ;
    // start is SDA falling while SCL high
    wire logic startCond = pinsIn.scl & sclPrevQ & sdaPrevQ & ~pinsIn.sda;
    // Stop is SDA rising while SCL high
    wire logic stopCond = pinsIn.scl & sclPrevQ & ~sdaPrevQ & pinsIn.sda;
    wire logic byteDone = bitCntQ == BYTE_BITS;
    // seven address bits against own address
    wire logic addrHit = shiftQ[7:1] == ownAddrQ;

    // prescale by 32, then select plus one periods
    wire logic preWrap = subClkTick & (preCntQ == TO_PRESCALE_LAST);
    wire logic toCounting = toRunQ & tocQ[TOC_EN_BIT] & active;
    // expiry when the last prescaled period ends
    wire logic toExpire = toCounting & ~sclFall & preWrap & (perCntQ == tocQ[5:0]);

    // APB answer, one wait state
    // Registered so read data and ready come straight from flops
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            preadyQ <= 1'b0;
            prdataQ <= 32'h0000_0000;
            pslverrQ <= 1'b0;
        end else if (clkEn) begin
            preadyQ <= apbAccess & ~preadyQ;
            prdataQ <= (apbAccess & ~preadyQ & ~pwrite) ? {24'h00_0000, rdByte} : 32'h0000_0000;
            pslverrQ <= apbAccess & ~preadyQ & ~mapped;
        end
    end

    // First control and own address, untouched by time-out
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl0Q <= CTRL0_RESET;
            ownAddrQ <= ADDR_RESET;
        end else if (clkEn) begin
            if (wrCtrl0) begin
                ctrl0Q <= pwdata[7:0];
            end
            if (wrAddr) begin
                ownAddrQ <= pwdata[6:0];
            end
        end
    end

    // Time-out control register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tocQ <= TOC_RESET;
        end else if (clkEn) begin
            if (wrToc) begin
                tocQ <= pwdata[7:0];
            end
            if (toExpire) begin
                tocQ[TOC_EN_BIT] <= 1'b0;
                tocQ[TOC_FLAG_BIT] <= 1'b1;
            end
        end
    end

    // Time-out counters
    // Cleared on every SCL fall, so only a stalled bus expires
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            toRunQ <= 1'b0;
            preCntQ <= 5'h00;
            perCntQ <= 6'h00;
        end else if (clkEn) begin
            if (!active || toExpire || stopCond) begin
                toRunQ <= 1'b0;
                preCntQ <= 5'h00;
                perCntQ <= 6'h00;
            end else if (stateQ == ST_ADDR && sclFall && byteDone && addrHit) begin
                toRunQ <= 1'b1;
                preCntQ <= 5'h00;
                perCntQ <= 6'h00;
            end else if (sclFall) begin
                // each SCL fall restarts from zero
                preCntQ <= 5'h00;
                perCntQ <= 6'h00;
            end else if (toCounting && subClkTick) begin
                preCntQ <= preCntQ + 5'h01;
                if (preWrap) begin
                    perCntQ <= perCntQ + 6'h01;
                end
            end
        end
    end

    // Serial engine, second control register and data register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stateQ <= ST_IDLE;
            shiftQ <= 8'h00;
            bitCntQ <= 4'h0;
            sclPrevQ <= 1'b1;
            sdaPrevQ <= 1'b1;
            sclOeNQ <= 1'b1;
            sdaOeNQ <= 1'b1;
            matchQ <= 1'b0;
            busyQ <= 1'b0;
            txSelQ <= 1'b0;
            txAckQ <= 1'b0;
            srwQ <= 1'b0;
            rxAckQ <= RXACK_RESET;
            dataQ <= DATA_RESET;
            irqQ <= 1'b0;
        end else if (clkEn) begin
            // Previous line levels for edge detection
            sclPrevQ <= pinsIn.scl;
            sdaPrevQ <= pinsIn.sda;
            irqQ <= 1'b0;
            if (wrCtrl1) begin
                txSelQ <= pwdata[CTRL1_TXSEL_BIT];
                txAckQ <= pwdata[CTRL1_TXACK_BIT];
            end
            // software writes the shared data register
            if (wrData) begin
                dataQ <= pwdata[7:0];
            end
            if (!active || toExpire) begin
                // slave logic and second control to reset state
                stateQ <= ST_IDLE;
                bitCntQ <= 4'h0;
                sclOeNQ <= 1'b1;
                sdaOeNQ <= 1'b1;
                matchQ <= 1'b0;
                busyQ <= 1'b0;
                txSelQ <= 1'b0;
                txAckQ <= 1'b0;
                srwQ <= 1'b0;
                rxAckQ <= RXACK_RESET;
                irqQ <= toExpire;
            end else if (startCond) begin
                busyQ <= 1'b1;
                matchQ <= 1'b0;
                stateQ <= ST_ADDR;
                bitCntQ <= 4'h0;
                sclOeNQ <= 1'b1;
                sdaOeNQ <= 1'b1;
            end else if (stopCond) begin
                busyQ <= 1'b0;
                matchQ <= 1'b0;
                stateQ <= ST_IDLE;
                sclOeNQ <= 1'b1;
                sdaOeNQ <= 1'b1;
            end else begin
                unique case (stateQ)
                    ST_IDLE: begin
                        sdaOeNQ <= 1'b1;
                    end
                    ST_ADDR: begin
                        if (sclRise && !byteDone) begin
                            shiftQ <= {shiftQ[6:0], pinsIn.sda};
                            bitCntQ <= bitCntQ + 4'h1;
                        end else if (sclFall && byteDone) begin
                            if (addrHit) begin
                                matchQ <= 1'b1;
                                irqQ <= 1'b1;
                                srwQ <= shiftQ[0];
                                // pull SDA low for ninth clock
                                sdaOeNQ <= 1'b0;
                                stateQ <= ST_ADDR_ACK;
                            end else begin
                                stateQ <= ST_IDLE;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (sclFall) begin
                            sdaOeNQ <= 1'b1;
                            sclOeNQ <= 1'b0;
                            stateQ <= ST_HOLD;
                        end
                    end
                    ST_HOLD: begin
                        if (wrData && txSelQ) begin
                            shiftQ <= pwdata[7:0];
                            sdaOeNQ <= pwdata[7];
                            // Stretch kept one more cycle for data setup
                            bitCntQ <= 4'h0;
                            stateQ <= ST_TX;
                        end else if (rdData && !txSelQ) begin
                            sclOeNQ <= 1'b1;
                            bitCntQ <= 4'h0;
                            stateQ <= ST_RX;
                        end
                    end
                    ST_RX: begin
                        if (sclRise && !byteDone) begin
                            shiftQ <= {shiftQ[6:0], pinsIn.sda};
                            bitCntQ <= bitCntQ + 4'h1;
                        end else if (sclFall && byteDone) begin
                            dataQ <= shiftQ;
                            // ack level driven on ninth clock
                            sdaOeNQ <= txAckQ;
                            irqQ <= 1'b1;
                            stateQ <= ST_RX_ACK;
                        end
                    end
                    ST_RX_ACK: begin
                        if (sclFall) begin
                            sdaOeNQ <= 1'b1;
                            sclOeNQ <= 1'b0;
                            stateQ <= ST_HOLD;
                        end
                    end
                    ST_TX: begin
                        if (!sclOeNQ) begin
                            // transmit releases after data write
                            // MSB is already on SDA, so a master that let
                            // SCL go early still sees valid setup
                            sclOeNQ <= 1'b1;
                        end else if (sclFall) begin
                            bitCntQ <= bitCntQ + 4'h1;
                            shiftQ <= {shiftQ[6:0], 1'b0};
                            if (bitCntQ == BYTE_BITS - 4'h1) begin
                                // Release SDA for the master's ack
                                sdaOeNQ <= 1'b1;
                                stateQ <= ST_TX_ACK;
                            end else begin
                                sdaOeNQ <= shiftQ[6];
                            end
                        end
                    end
                    ST_TX_ACK: begin
                        // sample master ack at ninth clock
                        if (sclRise) begin
                            rxAckQ <= pinsIn.sda;
                        end else if (sclFall) begin
                            irqQ <= 1'b1;
                            if (!rxAckQ) begin
                                sclOeNQ <= 1'b0;
                                stateQ <= ST_HOLD;
                            end else begin
                                // no ack, line released, await stop
                                sdaOeNQ <= 1'b1;
                                stateQ <= ST_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Outputs straight from flip-flops
    assign prdata = prdataQ;
    assign pready = preadyQ;
    assign pslverr = pslverrQ;
    assign irqPulse = irqQ;
    assign pinsOut = '{sclOut: 1'b0, sclOeN: sclOeNQ, sdaOut: 1'b0, sdaOeN: sdaOeNQ};
endmodule // tws_slave

// [bench/tws_slave_asserts.sv]
// Port checker of the two-wire slave, bound into its top module
module tws_slave_checker
    import tws_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Sub-clock, pins, interrupt
    input wire logic subClkTick,
    input wire tws_pins_in_s pinsIn,
    input wire tws_pins_out_s pinsOut,
    input wire logic irqPulse
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Bus answer timing
    property p_rdyOne; pready |=> !pready; endproperty
    a_rdyOne: assert property (p_rdyOne)
        else $error("pready held over one cycle");
    property p_rdyLat; psel && $rose(penable) |=> pready; endproperty
    a_rdyLat: assert property (p_rdyLat)
        else $error("pready not one cycle after access start");
    property p_errRdy; pslverr |-> pready && psel && penable; endproperty
    a_errRdy: assert property (p_errRdy)
        else $error("pslverr outside completion");
    property p_rdZero; !(pready && !pwrite) |-> prdata == 32'h0000_0000; endproperty
    a_rdZero: assert property (p_rdZero)
        else $error("prdata not zero outside read completion");
    // Interrupt and pin timing
    property p_irqOne; irqPulse |=> !irqPulse; endproperty
    a_irqOne: assert property (p_irqOne)
        else $error("interrupt longer than one cycle");
    property p_sdaLow; $changed(pinsOut.sdaOeN) |-> !pinsIn.scl; endproperty
    a_sdaLow: assert property (p_sdaLow)
        else $error("data drive changed while clock high");
    property p_sclLow; $fell(pinsOut.sclOeN) |-> !pinsIn.scl; endproperty
    a_sclLow: assert property (p_sclLow)
        else $error("stretch began with clock high");
    property p_hold;
        !pinsOut.sclOeN && !psel && !$past(psel) && !subClkTick && !$past(subClkTick) |=> !pinsOut.sclOeN;
    endproperty
    a_hold: assert property (p_hold)
        else $error("stretch ended without software access");
    // Main scenarios reached
    c_irq: cover property (irqPulse);
    c_err: cover property (pslverr);
    c_str: cover property ($fell(pinsOut.sclOeN));
endmodule // tws_slave_checker

bind tws_slave tws_slave_checker u_chk (
    .sys_clk, .rst, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
    .subClkTick, .pinsIn, .pinsOut, .irqPulse
);

// [bench/tws_master_model.sv]
// Behavioural two-wire bus master with open-drain drive
module tws_master_model (
    // Clock
    input wire logic sys_clk,
    // Wire levels
    input wire logic scl,
    input wire logic sda,
    // Enables, low pulls the line down
    output logic sclOeN,
    output logic sdaOeN,
    // Clock held low too long
    output logic stuck
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus
    initial begin
        sclOeN = 1'b1;
        sdaOeN = 1'b1;
        stuck = 1'b0;
    end
    // Half bit of four clocks
    task automatic hp;
        repeat (4) @(posedge sys_clk);
    endtask
    // Release clock, wait out stretching
    task automatic sclUp;
        int n;
        sclOeN <= 1'b1;
        for (n = 0; n < 400; n++) begin
            @(posedge sys_clk);
            if (scl === 1'b1) break;
        end
        if (n == 400) stuck <= 1'b1;
        hp();
    endtask
    task automatic start;
        sdaOeN <= 1'b0;
        hp();
        sclOeN <= 1'b0;
        hp();
    endtask
    task automatic stop;
        sdaOeN <= 1'b0;
        hp();
        sclUp();
        sdaOeN <= 1'b1;
        hp();
    endtask
    // One bit out and in
    task automatic bitIo(input logic d, output logic r);
        sdaOeN <= d;
        hp();
        sclUp();
        r = sda;
        sclOeN <= 1'b0;
        hp();
    endtask
    task automatic byteIo(input logic [7:0] d, input logic ackIn, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) bitIo(d[i], q[i]);
        bitIo(ackIn, ack);
    endtask
endmodule // tws_master_model

// [bench/tws_slave_bench.sv]
// Self-checking bench of the two-wire slave with time-out
module tws_slave_bench
    import tws_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst, clkEn, psel, penable, pwrite, subClkTick;
    logic pready, pslverr, irqPulse, mSclOeN, mSdaOeN, stuck, e, ack;
    logic [7:0] paddr, b;
    logic [31:0] pwdata, prdata, q;
    tws_pins_in_s pinsIn;
    tws_pins_out_s pinsOut;
    int err_total = 0;
    int cmp_count = 0;
    int irqCnt = 0;
    int n;
    // Open-drain wires with pull-ups
    assign pinsIn = {pinsOut.sclOeN & mSclOeN, pinsOut.sdaOeN & mSdaOeN};
    // Device and bus master
    tws_slave u_dut (
        .sys_clk, .rst, .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .subClkTick, .pinsIn, .pinsOut, .irqPulse
    );
    tws_master_model u_mst (
        .sys_clk, .scl(pinsIn.scl), .sda(pinsIn.sda), .sclOeN(mSclOeN), .sdaOeN(mSdaOeN), .stuck
    );
    // Clock and interrupt tally
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (irqPulse === 1'b1) irqCnt++;
    // Compare and verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("Compares %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
        if (k == 50) begin
            err_total++;
            summarize();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, {24'h00_0000, x});
    endtask
    // Reset values, writable time-out byte, unmapped place
    task automatic tRegs;
        rd(OFF_CTRL0, 8'h00);
        rd(OFF_CTRL1, 8'h01);
        rd(OFF_ADDR, 8'h00);
        rd(OFF_TOC, 8'h00);
        wr(OFF_TOC, 8'h7F);
        rd(OFF_TOC, 8'h7F);
        rd(8'h14, 8'h00);
        chk(e, 1'b1);
        $display("Register test done");
    endtask
    // Address ignored unless mode 110 and enable
    task automatic tOff;
        logic [7:0] m [2] = '{8'h06, 8'h0B};
        wr(OFF_ADDR, 8'h3B);
        foreach (m[i]) begin
            wr(OFF_CTRL0, m[i]);
            u_mst.start();
            u_mst.byteIo(8'h76, 1'b1, b, ack);
            chk(ack, 1'b1);
            u_mst.stop();
        end
        $display("Mode gate test done");
    endtask
    // Master writes with ticks running, counter kept clear by falls
    task automatic tWr;
        wr(OFF_TOC, 8'h81);
        wr(OFF_CTRL0, 8'h0E);
        subClkTick <= 1'b1;
        u_mst.start();
        rd(OFF_CTRL1, 8'h21);
        n = irqCnt;
        u_mst.byteIo(8'h76, 1'b1, b, ack);
        chk(ack, 1'b0);
        chk(irqCnt, n + 1);
        rd(OFF_CTRL1, 8'h61);
        chk(pinsOut.sclOeN, 1'b0);
        apb(1'b0, OFF_DATA, 32'h0000_0000);
        chk(pinsOut.sclOeN, 1'b1);
        u_mst.byteIo(8'hC1, 1'b1, b, ack);
        chk(ack, 1'b0);
        wr(OFF_CTRL1, 8'h08);
        rd(OFF_DATA, 8'hC1);
        u_mst.byteIo(8'h4D, 1'b1, b, ack);
        chk(ack, 1'b1);
        rd(OFF_DATA, 8'h4D);
        u_mst.stop();
        repeat (100) @(posedge sys_clk);
        subClkTick <= 1'b0;
        chk(irqCnt, n + 3);
        rd(OFF_TOC, 8'h81);
        wr(OFF_CTRL1, 8'h00);
        $display("Receive test done");
    endtask
    // Master reads two bytes, acks the first only
    task automatic tRd;
        logic [7:0] v [2] = '{8'hB2, 8'h17};
        u_mst.start();
        u_mst.byteIo(8'h77, 1'b1, b, ack);
        chk(ack, 1'b0);
        rd(OFF_CTRL1, 8'h65);
        wr(OFF_CTRL1, 8'h10);
        for (int i = 0; i < 2; i++) begin
            wr(OFF_DATA, v[i]);
            u_mst.byteIo(8'hFF, i[0], b, ack);
            chk(b, v[i]);
            rd(OFF_CTRL1, 8'h74 | i[7:0]);
            chk(pinsOut.sclOeN, i[0]);
        end
        chk(pinsOut.sdaOeN, 1'b1);
        u_mst.stop();
        wr(OFF_CTRL1, 8'h00);
        $display("Transmit test done");
    endtask
    // Frozen enable hides a start from the slave
    task automatic tFrz;
        clkEn <= 1'b0;
        u_mst.start();
        clkEn <= 1'b1;
        @(posedge sys_clk);
        rd(OFF_CTRL1, 8'h05);
        u_mst.stop();
        $display("Enable freeze test done");
    endtask
    // Other address, then own address as data
    task automatic tMiss;
        n = irqCnt;
        u_mst.start();
        u_mst.byteIo(8'h78, 1'b1, b, ack);
        chk(ack, 1'b1);
        rd(OFF_CTRL1, 8'h25);
        u_mst.byteIo(8'h76, 1'b1, b, ack);
        chk(ack, 1'b1);
        chk(irqCnt, n);
        u_mst.stop();
        $display("Mismatch test done");
    endtask
    // Master stalls after match until time-out
    task automatic tTmo;
        int c;
        u_mst.start();
        u_mst.byteIo(8'h76, 1'b1, b, ack);
        subClkTick <= 1'b1;
        for (c = 0; c < 300; c++) begin
            @(posedge sys_clk);
            if (irqPulse === 1'b1) break;
        end
        chk(c >= 62 && c <= 67, 1'b1);
        repeat (4) @(posedge sys_clk);
        subClkTick <= 1'b0;
        @(posedge sys_clk);
        chk(pinsOut.sclOeN & pinsOut.sdaOeN, 1'b1);
        chk({pinsOut.sclOut, pinsOut.sdaOut}, 32'h0000_0000);
        rd(OFF_TOC, 8'h41);
        rd(OFF_CTRL1, 8'h01);
        rd(OFF_ADDR, 8'h3B);
        rd(OFF_CTRL0, 8'h0E);
        wr(OFF_TOC, 8'h00);
        rd(OFF_TOC, 8'h00);
        u_mst.stop();
        $display("Time-out test done");
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        clkEn = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        subClkTick = 1'b0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        tRegs();
        tOff();
        tWr();
        tRd();
        tFrz();
        tMiss();
        tTmo();
        chk(stuck, 1'b0);
        summarize();
    end
endmodule // tws_slave_bench
